// [shared/pcs_pkg.sv]
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package pcs_pkg;

  // ----------------------------------------------------------------------
  // Configuration map, dword byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] PCS_OFF_CMD_STAT = 8'h04;
  localparam logic [7:0] PCS_OFF_REV_CLS  = 8'h08;
  localparam logic [7:0] PCS_OFF_CLS_LAT  = 8'h0C;

  // Byte-level offsets of the registers
  localparam logic [7:0] PCS_OFF_COMMAND  = 8'h04;
  localparam logic [7:0] PCS_OFF_STATUS   = 8'h06;
  localparam logic [7:0] PCS_OFF_REVISION = 8'h08;
  localparam logic [7:0] PCS_OFF_CLASS    = 8'h09;
  localparam logic [7:0] PCS_OFF_CACHE_LN = 8'h0C;
  localparam logic [7:0] PCS_OFF_TENURE   = 8'h0D;

  // ----------------------------------------------------------------------
  // Command bit positions
  // ----------------------------------------------------------------------
  localparam int PCS_CMD_PARITY_RESPONSE_ENABLE = 6;
  localparam int PCS_CMD_SYSTEM_ERROR_ENABLE    = 8;

  // ----------------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------------
  localparam int PCS_ST_PARITY_ERROR_SEEN       = 15;
  localparam int PCS_ST_SYSTEM_ERROR_SIGNALED   = 14;
  localparam int PCS_ST_MASTER_ABORT_RECEIVED   = 13;
  localparam int PCS_ST_TARGET_ABORT_RECEIVED   = 12;
  localparam int PCS_ST_TARGET_ABORT_SIGNALED   = 11;
  localparam int PCS_ST_DATA_PARITY_REPORTED    = 8;

  // Sticky flags as a mask, and the fixed read-only pattern
  localparam logic [15:0] PCS_ST_STICKY_MASK    = 16'hF900;
  localparam logic [15:0] PCS_ST_FIXED_VALUE    = 16'h0210;

  // ----------------------------------------------------------------------
  // Identity and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  PCS_REVISION_DEFAULT = 8'h5A; // Arbitrary value
  localparam logic [23:0] PCS_CLASS_CODE       = 24'h06_0700;
  localparam logic [7:0]  PCS_CACHE_LN_RESET   = 8'h00;
  localparam logic [7:0]  PCS_TENURE_RESET     = 8'h00;
  localparam logic [7:0]  PCS_TENURE_CNT_MAX   = 8'hFF;
  localparam logic [7:0]  PCS_TENURE_CNT_ONE   = 8'h01;

  // Whole register state of the block
  typedef struct packed {
    logic [15:0] status;
    logic        system_error_signaled_en;
    logic        par_resp_en;
    logic [7:0]  cache_ln;
    logic [7:0]  tenure_lim;
    logic [7:0]  tenure_cnt;
    logic [31:0] rdata;
    logic        ack;
  } pcs_state_s;

endpackage

// [logic/pcs_config_status.sv]
`timescale 1ns/1ps
`default_nettype none
module pcs_config_status #(
  parameter logic [7:0] REVISION = pcs_pkg::PCS_REVISION_DEFAULT
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Configuration cycle port
  input  wire logic        cfg_req_i,
  input  wire logic        cfg_we_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_ack_o,
  // Bus error events as one-cycle pulses, plus the master-active level
  input  wire logic        addr_parity_err_i,
  input  wire logic        data_parity_err_i,
  input  wire logic        perr_seen_i,
  input  wire logic        master_active_i,
  input  wire logic        master_abort_i,
  input  wire logic        target_abort_rcvd_i,
  input  wire logic        target_abort_sent_i,
  // Initiator tenure
  input  wire logic        frame_start_i,
  input  wire logic        init_busy_i,
  input  wire logic        gnt_i,
  output logic             end_tenure_o,
  // Controls seen by the rest of the device
  output logic             serr_drive_o,
  output logic      [7:0]  cache_line_size_o
);
  import pcs_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  pcs_state_s state_ff;
  pcs_state_s nxt_state;

  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [15:0] status_view;
  logic        wr_cmd_stat;
  logic        wr_cls_lat;
  logic        serr_now;
  logic        tenure_expired;

  // System error only for address parity with both enables
  assign serr_now = addr_parity_err_i && state_ff.system_error_signaled_en
                    && state_ff.par_resp_en;

  // Count reached limit while our transaction still runs
  assign tenure_expired = init_busy_i && !frame_start_i
                          && (state_ff.tenure_cnt >= state_ff.tenure_lim);

  // Give up the bus once grant is gone
  assign end_tenure_o = tenure_expired && !gnt_i;

  assign serr_drive_o      = serr_now;
  assign cfg_rdata_o       = state_ff.rdata;
  assign cfg_ack_o         = state_ff.ack;
  assign cache_line_size_o = state_ff.cache_ln;

  // Status as read: sticky flags over the fixed pattern
  assign status_view = (state_ff.status & PCS_ST_STICKY_MASK)
                       | PCS_ST_FIXED_VALUE;

  assign wr_cmd_stat = cfg_req_i && cfg_we_i
                       && (cfg_addr_i == PCS_OFF_CMD_STAT);
  assign wr_cls_lat  = cfg_req_i && cfg_we_i
                       && (cfg_addr_i == PCS_OFF_CLS_LAT);

  // ----------------------------------------------------------------------
  // Status event sources
  // ----------------------------------------------------------------------
  always_comb
  begin
    set_vec = 16'h0000;
    set_vec[PCS_ST_PARITY_ERROR_SEEN] = addr_parity_err_i
                                        || data_parity_err_i;
    set_vec[PCS_ST_SYSTEM_ERROR_SIGNALED] = serr_now;
    set_vec[PCS_ST_MASTER_ABORT_RECEIVED] = master_abort_i;
    set_vec[PCS_ST_TARGET_ABORT_RECEIVED] = target_abort_rcvd_i;
    set_vec[PCS_ST_TARGET_ABORT_SIGNALED] = target_abort_sent_i;
    set_vec[PCS_ST_DATA_PARITY_REPORTED]  = perr_seen_i
                                            && master_active_i
                                            && state_ff.par_resp_en;
  end

  // Write-one-to-clear, status sits in byte lanes 2 and 3
  always_comb
  begin
    clr_vec = 16'h0000;
    if (wr_cmd_stat)
    begin
      if (cfg_be_i[2])
        clr_vec[7:0] = cfg_wdata_i[23:16];
      if (cfg_be_i[3])
        clr_vec[15:8] = cfg_wdata_i[31:24];
    end
    clr_vec = clr_vec & PCS_ST_STICKY_MASK;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    // Set beats clear in the same cycle
    nxt_state.status = ((state_ff.status & ~clr_vec) | set_vec)
                       & PCS_ST_STICKY_MASK;

    // Command: only the two enables are kept
    if (wr_cmd_stat && cfg_be_i[0])
      nxt_state.par_resp_en =
        cfg_wdata_i[PCS_CMD_PARITY_RESPONSE_ENABLE];
    if (wr_cmd_stat && cfg_be_i[1])
      nxt_state.system_error_signaled_en =
        cfg_wdata_i[PCS_CMD_SYSTEM_ERROR_ENABLE];

    // Revision and class dword takes no writes
    if (wr_cls_lat && cfg_be_i[0])
      nxt_state.cache_ln = cfg_wdata_i[7:0];
    if (wr_cls_lat && cfg_be_i[1])
      nxt_state.tenure_lim = cfg_wdata_i[15:8];

    // Tenure counter: zero at frame start, then one per busy clock, holding at 8'hFF
    if (frame_start_i)
      nxt_state.tenure_cnt = 8'h00;
    else if (init_busy_i && (state_ff.tenure_cnt != PCS_TENURE_CNT_MAX))
      nxt_state.tenure_cnt = state_ff.tenure_cnt + PCS_TENURE_CNT_ONE;

    // Read data, answered one cycle after the request
    nxt_state.ack   = cfg_req_i;
    nxt_state.rdata = state_ff.rdata;
    if (cfg_req_i && !cfg_we_i)
    begin
      unique case (cfg_addr_i)
        PCS_OFF_CMD_STAT:
        begin
          nxt_state.rdata = {status_view, 16'h0000};
          nxt_state.rdata[PCS_CMD_PARITY_RESPONSE_ENABLE] =
            state_ff.par_resp_en;
          nxt_state.rdata[PCS_CMD_SYSTEM_ERROR_ENABLE] =
            state_ff.system_error_signaled_en;
        end
        PCS_OFF_REV_CLS:
          nxt_state.rdata = {PCS_CLASS_CODE, REVISION};
        PCS_OFF_CLS_LAT:
          nxt_state.rdata = {16'h0000, state_ff.tenure_lim,
                             state_ff.cache_ln};
        default:
          nxt_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_ff.status      <= 16'h0000;
      state_ff.system_error_signaled_en  <= 1'b0;
      state_ff.par_resp_en <= 1'b0;
      state_ff.cache_ln    <= PCS_CACHE_LN_RESET;
      state_ff.tenure_lim  <= PCS_TENURE_RESET;
      state_ff.tenure_cnt  <= 8'h00;
      state_ff.rdata       <= 32'h0000_0000;
      state_ff.ack         <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

endmodule
`default_nettype wire

// [tb/pcs_config_status_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pcs_config_status_props
  import pcs_pkg::*;
#(
  parameter logic [7:0] REVISION = PCS_REVISION_DEFAULT
) (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        cfg_req_i,
  input wire logic        cfg_we_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [3:0]  cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_ack_o,
  input wire logic        addr_parity_err_i,
  input wire logic        data_parity_err_i,
  input wire logic        perr_seen_i,
  input wire logic        master_active_i,
  input wire logic        master_abort_i,
  input wire logic        target_abort_rcvd_i,
  input wire logic        target_abort_sent_i,
  input wire logic        frame_start_i,
  input wire logic        init_busy_i,
  input wire logic        gnt_i,
  input wire logic        end_tenure_o,
  input wire logic        serr_drive_o,
  input wire logic [7:0]  cache_line_size_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Read of the command and status dword
  sequence rd_st;
    cfg_req_i && !cfg_we_i && cfg_addr_i == PCS_OFF_CMD_STAT;
  endsequence
  // Fixed fields, identity bytes and all event flags but data parity reported as seen by reads, then system error, tenure end and cache line size outputs
  AST_FIXED: assert property (rd_st |=> (cfg_rdata_o[31:16] &
    ~PCS_ST_STICKY_MASK) == PCS_ST_FIXED_VALUE) else $error("fixed bits");
  AST_REVCLS: assert property (cfg_req_i && !cfg_we_i &&
    cfg_addr_i == PCS_OFF_REV_CLS |=> cfg_rdata_o == {24'h06_0700, REVISION})
    else $error("revision or class wrong");
  AST_PAR: assert property ((addr_parity_err_i || data_parity_err_i)
    ##[1:3] rd_st |=> cfg_rdata_o[31]) else $error("parity flag lost");
  AST_SYSERR: assert property (serr_drive_o ##[1:3] rd_st
    |=> cfg_rdata_o[30]) else $error("system error flag lost");
  AST_MABT: assert property (master_abort_i ##[1:3] rd_st
    |=> cfg_rdata_o[29]) else $error("master abort flag lost");
  AST_TARX: assert property (target_abort_rcvd_i ##[1:3] rd_st
    |=> cfg_rdata_o[28]) else $error("received abort flag lost");
  AST_TASG: assert property (target_abort_sent_i ##[1:3] rd_st
    |=> cfg_rdata_o[27]) else $error("signaled abort flag lost");
  AST_SERR: assert property (serr_drive_o |-> addr_parity_err_i)
    else $error("system error without address parity");
  AST_END: assert property (end_tenure_o |-> init_busy_i && !gnt_i &&
    !frame_start_i) else $error("tenure ended while granted");
  AST_CACHE: assert property (cfg_req_i && cfg_we_i && cfg_be_i[0] &&
    cfg_addr_i == PCS_OFF_CLS_LAT |=> cache_line_size_o ==
    $past(cfg_wdata_i[7:0])) else $error("cache line size not loaded");
endmodule
bind pcs_config_status pcs_config_status_props #(.REVISION(REVISION))
  i_pcs_config_status_props (.*);
`default_nettype wire

// [tb/pcs_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pcs_bus_model (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       start_i,
  input  wire logic       end_tenure_i,
  input  wire logic [5:0] ev_i,
  output logic            frame_start_o,
  output logic            init_busy_o,
  output logic      [5:0] ev_o
);
  logic busy_ff;
  // Initiator keeps its transaction until told to terminate
  always_ff @(posedge clk_i)
  begin
    busy_ff <= !sys_rst_i && (start_i || busy_ff) && !end_tenure_i;
  end
  // Frame start and bus events as single-cycle pulses
  assign frame_start_o = start_i;
  assign init_busy_o   = busy_ff || start_i;
  assign ev_o          = ev_i;
endmodule
`default_nettype wire

// [tb/pcs_config_status_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pcs_config_status_tb;
  import pcs_pkg::*;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, go = 1'b0, gnt_i = 1'b1;
  logic        cfg_req_i = 1'b0, cfg_we_i = 1'b0;
  logic [7:0]  cfg_addr_i = 8'h00, cache_line_size_o;
  logic [3:0]  cfg_be_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o;
  logic [5:0]  ev = 6'h00, ev_o;
  logic        cfg_ack_o, end_tenure_o, serr_drive_o, frame_start_i;
  logic        init_busy_i, master_active_i, addr_parity_err_i;
  logic        data_parity_err_i, perr_seen_i, master_abort_i;
  logic        target_abort_rcvd_i, target_abort_sent_i;
  int          n_mismatch = 0, samples_checked = 0, n;
  logic [15:0] flg [6] = '{16'hC000, 16'h8000, 16'h0100, 16'h2000,
                           16'h1000, 16'h0800};
  // Event pulses and master level taken from the bus model
  assign {target_abort_sent_i, target_abort_rcvd_i, master_abort_i,
          perr_seen_i, data_parity_err_i, addr_parity_err_i} = ev_o;
  assign master_active_i = init_busy_i;
  pcs_config_status i_pcs_config_status (.*);
  pcs_bus_model i_pcs_bus_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .start_i(go), .end_tenure_i(end_tenure_o), .ev_i(ev),
    .frame_start_o(frame_start_i), .init_busy_o(init_busy_i), .ev_o(ev_o));
  // Clock at 200 MHz
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One configuration access with an optional event pulse beside it
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d, input logic [31:0] x,
                     input logic [5:0] e);
    int k;
    @(posedge clk_i);
    cfg_req_i   <= 1'b1;
    cfg_we_i    <= w;
    cfg_addr_i  <= a;
    cfg_be_i    <= b;
    cfg_wdata_i <= d;
    ev          <= e;
    @(posedge clk_i);
    cfg_req_i <= 1'b0;
    ev        <= 6'h00;
    // Look at the answer once it has settled after the taking edge
    #1;
    k = 0;
    while (cfg_ack_o !== 1'b1 && k < 4)
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
    check({31'h0, cfg_ack_o}, 32'h1);
    if (!w)
      check(cfg_rdata_o, x);
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Register defaults, refused writes, events and tenure limit
  initial
  begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    acc(1, 8'h08, 4'hF, 32'hFFFF_FFFF, 32'h0, 6'h0);
    acc(0, 8'h08, 4'hF, 32'h0, {24'h06_0700, 8'h5A}, 6'h0);
    acc(0, 8'h0C, 4'hF, 32'h0, 32'h0, 6'h0);
    acc(0, 8'h04, 4'hF, 32'h0, 32'h0210_0000, 6'h0);
    acc(1, 8'h04, 4'h3, 32'h0000_FFFF, 32'h0, 6'h0);
    acc(1, 8'h0C, 4'hF, 32'hFFFF_0204, 32'h0, 6'h0);
    acc(0, 8'h0C, 4'hF, 32'h0, 32'h0000_0204, 6'h0);
    check({24'h0, cache_line_size_o}, 32'h0000_0004);
    acc(1, 8'h10, 4'hF, 32'hFFFF_FFFF, 32'h0, 6'h0);
    acc(0, 8'h10, 4'hF, 32'h0, 32'h0, 6'h0);
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      acc(1, 8'h04, 4'hC, 32'h0, 32'h0, 6'h01 << i);
      acc(0, 8'h04, 4'hF, 32'h0, {16'h0210 | flg[i], 16'h0140}, 6'h0);
      acc(1, 8'h04, 4'hC, 32'hFFFF_0000, 32'h0, 6'h0);
      acc(0, 8'h04, 4'hF, 32'h0, 32'h0210_0140, 6'h0);
    end
    acc(1, 8'h04, 4'hC, 32'hFFFF_0000, 32'h0, 6'h08);
    acc(0, 8'h04, 4'hF, 32'h0, 32'h2210_0140, 6'h0);
    acc(1, 8'h04, 4'hC, 32'hFFFF_0000, 32'h0, 6'h0);
    check({31'h0, end_tenure_o}, 32'h0);
    @(posedge clk_i);
    gnt_i <= 1'b0;
    #1;
    check({31'h0, end_tenure_o}, 32'h1);
    repeat (2) @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    #1;
    n = 0;
    while (end_tenure_o !== 1'b1 && n < 9)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(n, 32'd2);
    finish_test();
  end
  // Cuts a hung run short
  initial
  begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
